/* rtl/aio_pkg.sv */
/*
  constants, types and register map of the analog i/o block with bulk capture.
  assumes one 40 MHz clock and an AXI4-Lite master with 16 address bits.
*/
package aio_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned ADC_W         = 12;
  localparam int unsigned DAC_W         = 10;
  localparam int unsigned MAX_SAMPLES   = 8191;
  localparam int unsigned LEN_W         = 13;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam int unsigned STORE_WORDS   = 4096;
  // register byte offsets
  localparam logic [15:0] OFS_CTRL   = 16'h0000;
  localparam logic [15:0] OFS_STATE  = 16'h0004;
  localparam logic [15:0] OFS_LEN    = 16'h0008;
  localparam logic [15:0] OFS_RATE   = 16'h000C;
  localparam logic [15:0] OFS_CHAN   = 16'h0010;
  localparam logic [15:0] OFS_OUTCNT = 16'h0014;
  localparam logic [15:0] OFS_OUTUV  = 16'h0018;
  localparam logic [15:0] OFS_CNT0   = 16'h0020;
  localparam logic [15:0] OFS_UV0    = 16'h0030;
  localparam logic [15:0] STORE_BASE = 16'h8000;
  localparam int unsigned CTRL_TRIG_BIT = 0;
  // reset values
  localparam logic [12:0] LEN_RST  = 13'h0001;
  localparam logic [31:0] RATE_RST = 32'h00001B58;
  // scaling: uv = (c*UV_MUL+2^15)>>16, c = (uv*CNT_MUL+2^23)>>24
  localparam logic [21:0] UV_FULL  = 22'h325AA0;
  localparam logic [21:0] UV_MUL   = 22'h325AD2;
  localparam logic [18:0] CNT_MUL  = 19'h51574;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  localparam logic [1:0]  OUT_CHAN = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } cap_state_t;
  typedef struct packed {
    logic [1:0]  chan;
    logic [15:0] counts;
  } sample_t;
endpackage : aio_pkg

/* rtl/analog_io_bulk_capture.sv */
/*
  analog i/o control: three scaled inputs, one scaled output, bulk capture
  of one input into a ram slot, all behind an AXI4-Lite slave.
  assumes converter codes arrive as slow levels from another domain and that
  the converter holds each code stable well beyond two clock cycles.
*/
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module analog_io_bulk_capture #(
  parameter int unsigned CLK_HZ = aio_pkg::CLK_HZ
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic [15:0]       S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [15:0]       S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic [2:0][11:0]  ADC_CODE,
  output logic [9:0]             DAC_CODE,
  output logic                   DAC_LOAD,
  output logic                   CAPTURE_BUSY
);
  localparam logic [32:0] HZ = 33'(CLK_HZ);

  logic [2:0][11:0]    adc_s1_q;
  logic [2:0][11:0]    adc_s2_q;
  logic [3:0][15:0]    chan_cnt;
  aio_pkg::cap_state_t state_q;
  logic [12:0]         len_q;
  logic [31:0]         rate_q;
  logic [1:0]          chan_q;
  logic [15:0]         out_cnt_q;
  logic [21:0]         out_uv_q;
  logic [31:0]         acc_q;
  logic [32:0]         acc_sum;
  logic                tick;
  logic [12:0]         taken_q;
  logic [12:0]         wr_idx_q;
  logic                pend_q;
  aio_pkg::sample_t    pend_d;
  aio_pkg::sample_t    pend_q_data;
  aio_pkg::sample_t    fifo_out;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [31:0]         store [aio_pkg::STORE_WORDS];
  logic                aw_have_q;
  logic                w_have_q;
  logic [15:0]         aw_addr_q;
  logic [31:0]         w_data_q;
  logic [3:0]          w_strb_q;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic                do_wr;
  logic                trig;
  logic [31:0]         wmask;

  function automatic logic [15:0] scale12(input logic [11:0] c);
    scale12 = {c, c[11:8]}; // replicate so full code reaches 65535
  endfunction : scale12

  function automatic logic [21:0] to_uv(input logic [15:0] c);
    logic [37:0] p;
    p = 38'(c) * 38'(aio_pkg::UV_MUL) + 38'h0000008000;
    to_uv = p[37:16];
  endfunction : to_uv

  function automatic logic [15:0] to_cnt(input logic [21:0] uv);
    logic [40:0] p;
    logic [21:0] u;
    u = (uv > aio_pkg::UV_FULL) ? aio_pkg::UV_FULL : uv;
    p = 41'(u) * 41'(aio_pkg::CNT_MUL) + 41'h00000800000;
    to_cnt = p[39:24];
  endfunction : to_cnt

  // two-stage synchroniser on converter codes
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      adc_s1_q <= '0;
      adc_s2_q <= '0;
    end else begin
      adc_s1_q <= ADC_CODE;
      adc_s2_q <= adc_s1_q;
    end
  end

  // per-channel scaled counts; index 3 is the output setting
  for (genvar c = 0; c < 3; c++) begin : g_in
    assign chan_cnt[c] = scale12(adc_s2_q[c]);
  end
  assign chan_cnt[3] = out_cnt_q;

  // bus handshake terms
  assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take  = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign do_wr   = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign trig    = do_wr && (aw_addr_q == aio_pkg::OFS_CTRL)
                   && w_strb_q[0] && w_data_q[aio_pkg::CTRL_TRIG_BIT];

  // address and data are held separately, taken in either order
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {S_AXI_AWADDR[15:2], 2'h0};
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
      S_AXI_AWREADY <= !aw_take && !aw_have_q && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_take && !w_have_q && !S_AXI_BVALID;
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= aio_pkg::RESP_OK;
    end else if (do_wr) begin
      S_AXI_BVALID <= 1'b1;
      case (aw_addr_q)
        aio_pkg::OFS_CTRL, aio_pkg::OFS_LEN, aio_pkg::OFS_RATE,
        aio_pkg::OFS_CHAN, aio_pkg::OFS_OUTCNT,
        aio_pkg::OFS_OUTUV: S_AXI_BRESP <= aio_pkg::RESP_OK;
        default:            S_AXI_BRESP <= aio_pkg::RESP_ERR;
      endcase
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // capture configuration; refused while running so a capture stays coherent
  always_ff @(posedge REF_CLK) begin
    logic [31:0] v;
    v = (rate_q & ~wmask) | (w_data_q & wmask);
    if (RST) begin
      len_q  <= aio_pkg::LEN_RST;
      rate_q <= aio_pkg::RATE_RST;
      chan_q <= '0;
    end else if (do_wr && state_q != aio_pkg::ST_RUN) begin
      if (aw_addr_q == aio_pkg::OFS_LEN) begin
        v = (32'(len_q) & ~wmask) | (w_data_q & wmask);
        len_q <= (v > 32'(aio_pkg::MAX_SAMPLES)) ? 13'h1FFF : v[12:0];
      end
      if (aw_addr_q == aio_pkg::OFS_RATE) begin
        if (v == 32'h0) rate_q <= 32'h00000001;
        else if (33'(v) > HZ) rate_q <= HZ[31:0];
        else rate_q <= v;
      end
      if (aw_addr_q == aio_pkg::OFS_CHAN && w_strb_q[0]
          && w_data_q[1:0] != aio_pkg::OUT_CHAN) begin
        chan_q <= w_data_q[1:0];
      end
    end
  end

  // output setting as counts or microvolts; both views kept in step
  always_ff @(posedge REF_CLK) begin
    logic [31:0] v;
    logic [15:0] c;
    v = (32'(out_uv_q) & ~wmask) | (w_data_q & wmask);
    c = to_cnt(v[21:0]);
    if (RST) begin
      out_cnt_q <= '0;
      out_uv_q  <= '0;
      DAC_CODE  <= '0;
      DAC_LOAD  <= 1'b0;
    end else begin
      DAC_LOAD <= 1'b0;
      if (do_wr && aw_addr_q == aio_pkg::OFS_OUTCNT) begin
        v = (32'(out_cnt_q) & ~wmask) | (w_data_q & wmask);
        out_cnt_q <= v[15:0];
        out_uv_q  <= to_uv(v[15:0]);
        DAC_CODE  <= v[15:6];
        DAC_LOAD  <= 1'b1;
      end else if (do_wr && aw_addr_q == aio_pkg::OFS_OUTUV) begin
        out_cnt_q <= c;
        out_uv_q  <= (v[21:0] > aio_pkg::UV_FULL) ? aio_pkg::UV_FULL : v[21:0];
        DAC_CODE  <= c[15:6];
        DAC_LOAD  <= 1'b1;
      end
    end
  end

  // capture sequencer; a running capture ignores triggers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_q      <= aio_pkg::ST_IDLE;
      CAPTURE_BUSY <= 1'b0;
    end else begin
      case (state_q)
        aio_pkg::ST_IDLE, aio_pkg::ST_DONE: begin
          if (trig) begin
            state_q      <= aio_pkg::ST_RUN;
            CAPTURE_BUSY <= 1'b1;
          end
        end
        aio_pkg::ST_RUN: begin
          if (taken_q == len_q && wr_idx_q == len_q && !pend_q) begin
            state_q      <= aio_pkg::ST_DONE;
            CAPTURE_BUSY <= 1'b0;
          end
        end
        default: begin
          state_q      <= aio_pkg::ST_IDLE;
          CAPTURE_BUSY <= 1'b0;
        end
      endcase
    end
  end

  // rate pacing by phase accumulator: one tick per 1/rate second on average
  assign acc_sum = 33'(acc_q) + 33'(rate_q);
  assign tick    = (state_q == aio_pkg::ST_RUN) && (acc_sum >= HZ);
  always_ff @(posedge REF_CLK) begin
    if (RST || state_q != aio_pkg::ST_RUN) begin
      acc_q <= '0;
    end else begin
      acc_q <= tick ? 32'(acc_sum - HZ) : acc_sum[31:0];
    end
  end

  // sampler; a full fifo holds the sample and later ticks are dropped
  assign pend_d = '{chan: chan_q, counts: chan_cnt[chan_q]};
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pend_q      <= 1'b0;
      pend_q_data <= '0;
      taken_q     <= '0;
    end else if (trig && state_q != aio_pkg::ST_RUN) begin
      pend_q  <= 1'b0;
      taken_q <= '0;
    end else begin
      if (pend_q && fifo_in_ready) begin
        pend_q  <= 1'b0;
        taken_q <= taken_q + 13'h0001;
      end else if (!pend_q && tick && taken_q != len_q) begin
        pend_q      <= 1'b1;
        pend_q_data <= pend_d;
      end
    end
  end

  sample_fifo #(
    .WIDTH ($bits(aio_pkg::sample_t)),
    .DEPTH (aio_pkg::FIFO_DEPTH)
  ) sample_fifo_inst (
    .clk       (REF_CLK),
    .rst       (RST),
    .in_data   (pend_q_data),
    .in_valid  (pend_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // drain stalls while a store read uses the ram
  assign fifo_out_ready = (state_q == aio_pkg::ST_RUN)
                          && !(ar_take && S_AXI_ARADDR[15]);

  // ram slot writer, from the slot start, ascending
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wr_idx_q <= '0;
    end else if (trig && state_q != aio_pkg::ST_RUN) begin
      wr_idx_q <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      wr_idx_q <= wr_idx_q + 13'h0001;
    end
  end

  // one slot of 16-bit samples, two per word, even-numbered sample in the low half
  always_ff @(posedge REF_CLK) begin
    if (fifo_out_valid && fifo_out_ready) begin
      if (wr_idx_q[0]) store[wr_idx_q[12:1]][31:16] <= fifo_out.counts;
      else store[wr_idx_q[12:1]][15:0] <= fifo_out.counts;
    end
  end

  // read channel: data registered, valid one cycle after the address
  always_ff @(posedge REF_CLK) begin
    logic [15:0] a;
    a = {S_AXI_ARADDR[15:2], 2'h0};
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= aio_pkg::RESP_OK;
    end else begin
      S_AXI_ARREADY <= !ar_take && !S_AXI_RVALID;
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= aio_pkg::RESP_OK;
        S_AXI_RDATA  <= '0;
        if (a[15]) begin
          S_AXI_RDATA <= store[a[13:2]];
        end else if (a[15:4] == aio_pkg::OFS_CNT0[15:4]) begin
          S_AXI_RDATA <= 32'(chan_cnt[a[3:2]]);
        end else if (a[15:4] == aio_pkg::OFS_UV0[15:4]) begin
          S_AXI_RDATA <= 32'(to_uv(chan_cnt[a[3:2]]));
        end else begin
          case (a)
            aio_pkg::OFS_CTRL:   S_AXI_RDATA <= '0;
            aio_pkg::OFS_STATE: begin
              case (state_q)
                aio_pkg::ST_RUN:  S_AXI_RDATA <= 32'h00000001;
                aio_pkg::ST_DONE: S_AXI_RDATA <= 32'h00000002;
                default:          S_AXI_RDATA <= 32'h00000000;
              endcase
            end
            aio_pkg::OFS_LEN:    S_AXI_RDATA <= 32'(len_q);
            aio_pkg::OFS_RATE:   S_AXI_RDATA <= rate_q;
            aio_pkg::OFS_CHAN:   S_AXI_RDATA <= 32'(chan_q);
            aio_pkg::OFS_OUTCNT: S_AXI_RDATA <= 32'(out_cnt_q);
            aio_pkg::OFS_OUTUV:  S_AXI_RDATA <= 32'(out_uv_q);
            default:             S_AXI_RRESP <= aio_pkg::RESP_ERR;
          endcase
        end
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule : analog_io_bulk_capture

/* rtl/sample_fifo.sv */
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module sample_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             push;
  logic             pop;
  // pointers one bit wider than the index so full and empty differ
  assign in_ready  = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  // pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule : sample_fifo

/* tb/analog_io_bulk_capture_sva.sv */
/*
  checker for the analog i/o block, bound to its top ports.
  assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/1ps
module aio_checker #(
  parameter int unsigned CLK_HZ = aio_pkg::CLK_HZ
) (
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [9:0]  DAC_CODE,
  input wire logic        DAC_LOAD,
  input wire logic        CAPTURE_BUSY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // both write halves taken together, then the answer
  sequence s_wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  property p_wr_answer; s_wr_take |-> ##2 S_AXI_BVALID; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer not on time");
  property p_rd_answer; s_rd_take |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer not on time");
  property p_rd_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  // the converter never sees a new code without its load strobe
  property p_dac_load; $changed(DAC_CODE) |-> DAC_LOAD; endproperty
  a_dac_load: assert property (p_dac_load) else $error("output code changed without load");
  property p_load_pulse; DAC_LOAD |=> !DAC_LOAD; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load strobe too long");
  property p_load_by_write; DAC_LOAD |-> !S_AXI_AWREADY; endproperty
  a_load_by_write: assert property (p_load_by_write) else $error("load outside a write");
  property p_busy_by_write; $rose(CAPTURE_BUSY) |-> !S_AXI_AWREADY; endproperty
  a_busy_by_write: assert property (p_busy_by_write) else $error("capture began without trigger");
endmodule : aio_checker
bind analog_io_bulk_capture aio_checker #(.CLK_HZ(CLK_HZ)) aio_checker_inst (
  .REF_CLK(REF_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .DAC_CODE(DAC_CODE), .DAC_LOAD(DAC_LOAD), .CAPTURE_BUSY(CAPTURE_BUSY)
);

/* tb/analog_io_bulk_capture_test.sv */
/*
  self-checking bench: bus tasks and one task per scenario.
  assumes the converter model on the far side and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module analog_io_bulk_capture_test;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [15:0]      awaddr = 16'h0000;
  logic [15:0]      araddr = 16'h0000;
  logic [31:0]      wdata = 32'h00000000;
  logic             awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic             awry, wry, bv, arry, rv, load, busy;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  logic [9:0]       dac, dac_level;
  logic [2:0][11:0] codes = {12'hFFF, 12'h5A3, 12'h000};
  logic [2:0][11:0] adc;
  int               mismatches = 0;
  int               checked = 0;
  int               busy_cyc = 0;
  always #12.5 clk = ~clk;
  // capture length in cycles, for the pacing check
  always @(posedge clk) if (busy === 1'b1) busy_cyc++;
  analog_io_bulk_capture analog_io_bulk_capture_inst (
    .REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awry),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wry),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arry), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .ADC_CODE(adc), .DAC_CODE(dac), .DAC_LOAD(load),
    .CAPTURE_BUSY(busy));
  converter_model converter_model_inst (
    .clk(clk), .set_code(codes), .adc_code(adc), .dac_code(dac), .dac_load(load),
    .dac_level(dac_level));
  // expectations from the scaling rules, not from the design
  function automatic logic [15:0] scale(input logic [11:0] c);
    return {c, c[11:8]};
  endfunction : scale
  // full scale 65535 is 3.3 V, rounded to the nearest microvolt
  function automatic logic [31:0] to_uv(input logic [15:0] c);
    logic [47:0] p;
    p = 48'(c) * 48'(aio_pkg::UV_FULL) + 48'h000000007FFF;
    return 32'(p / 48'h00000000FFFF);
  endfunction : to_uv
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic timeout;
    mismatches++;
    give_verdict();
  endtask : timeout
  // write: both halves offered together, each released when taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    // bready follows bvalid by a cycle so the held answer is exercised
    do begin
      @(posedge clk);
      n++;
      if (awv && awry) awv <= 1'b0;
      if (wv && wry) wv <= 1'b0;
      if (bv === 1'b1 && bry !== 1'b1) bry <= 1'b1;
    end while (!(bv === 1'b1 && bry === 1'b1) && n < 200);
    bry <= 1'b0;
    r = bresp;
    if (n >= 200) timeout();
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    // rready follows rvalid by a cycle so the held data is exercised
    do begin
      @(posedge clk);
      n++;
      if (arv && arry) arv <= 1'b0;
      if (rv === 1'b1 && rry !== 1'b1) rry <= 1'b1;
    end while (!(rv === 1'b1 && rry === 1'b1) && n < 200);
    rry <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 200) timeout();
  endtask : rd
  task automatic wrok(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CHK(r, aio_pkg::RESP_OK)
  endtask : wrok
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(r, aio_pkg::RESP_OK)
    `CHK(d, e)
  endtask : rdchk
  // polls the state word; a capture not done after 200 polls fails the test
  task automatic wait_done;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd(aio_pkg::OFS_STATE, d, r);
      n++;
    end while (d !== 32'h00000002 && n < 200);
    if (n >= 200) timeout();
  endtask : wait_done
  task automatic t_defaults;
    rdchk(aio_pkg::OFS_LEN, 32'h00000001);
    rdchk(aio_pkg::OFS_RATE, 32'h00001B58);
    rdchk(aio_pkg::OFS_STATE, 32'h00000000);
  endtask : t_defaults
  task automatic t_inputs;
    for (int k = 0; k < 3; k++) begin
      rdchk(aio_pkg::OFS_CNT0 + 16'(4 * k), {16'h0000, scale(codes[k])});
      rdchk(aio_pkg::OFS_UV0 + 16'(4 * k), to_uv(scale(codes[k])));
    end
  endtask : t_inputs
  task automatic t_output;
    wrok(aio_pkg::OFS_OUTCNT, 32'h0000FFFF);
    repeat (2) @(posedge clk);
    `CHK(dac_level, 10'h3FF)
    rdchk(aio_pkg::OFS_CNT0 + 16'h000C, 32'h0000FFFF);
    wrok(aio_pkg::OFS_OUTUV, 32'h00192D50);
    repeat (2) @(posedge clk);
    `CHK(dac_level, 10'h1FF)
  endtask : t_output
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    wrok(aio_pkg::OFS_CHAN, 32'h00000001);
    wrok(aio_pkg::OFS_CHAN, 32'h00000003);
    rdchk(aio_pkg::OFS_CHAN, 32'h00000001);
    wrok(aio_pkg::OFS_LEN, 32'h00002328);
    rdchk(aio_pkg::OFS_LEN, 32'h00001FFF);
    rd(16'h0040, d, r);
    `CHK({r, d}, {aio_pkg::RESP_ERR, 32'h00000000})
    wr(aio_pkg::STORE_BASE, 32'h00000000, r);
    `CHK(r, aio_pkg::RESP_ERR)
  endtask : t_regs
  // two captures: the second must overwrite from the slot start only
  task automatic t_capture;
    logic [31:0] d;
    logic [1:0]  r;
    wrok(aio_pkg::OFS_LEN, 32'h00000003);
    wrok(aio_pkg::OFS_RATE, 32'h000F4240);
    busy_cyc = 0;
    wrok(aio_pkg::OFS_CTRL, 32'h00000001);
    wrok(aio_pkg::OFS_CTRL, 32'h00000001);
    rdchk(aio_pkg::OFS_STATE, 32'h00000001);
    wait_done();
    `CHK(busy_cyc inside {[115:140]}, 1'b1)
    rdchk(aio_pkg::STORE_BASE, {scale(12'h5A3), scale(12'h5A3)});
    rd(aio_pkg::STORE_BASE + 16'h0004, d, r);
    `CHK(d[15:0], scale(12'h5A3))
    wrok(aio_pkg::OFS_CHAN, 32'h00000002);
    wrok(aio_pkg::OFS_LEN, 32'h00000001);
    wrok(aio_pkg::OFS_CTRL, 32'h00000001);
    wait_done();
    rdchk(aio_pkg::STORE_BASE, {scale(12'h5A3), scale(12'hFFF)});
  endtask : t_capture
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_inputs();
    t_output();
    t_regs();
    t_capture();
    give_verdict();
  end
endmodule : analog_io_bulk_capture_test

/* tb/converter_model.sv */
/*
  behavioural converter pair on the far side: three input codes and one output.
  assumes the bench sets the input codes and reads back the output level.
*/
`timescale 1ns/1ps
module converter_model (
  input  wire logic             clk,
  input  wire logic [2:0][11:0] set_code,
  output logic      [2:0][11:0] adc_code,
  input  wire logic [9:0]       dac_code,
  input  wire logic             dac_load,
  output logic      [9:0]       dac_level
);
  // input codes change only at edges, as a real converter register would
  always_ff @(posedge clk) begin
    adc_code <= set_code;
  end
  // ten-bit converter latches only on the load pulse
  always_ff @(posedge clk) begin
    if (dac_load) begin
      dac_level <= dac_code;
    end
  end
endmodule : converter_model
